/* mode_watchdog_pkg.sv */
/*
 * Shared constants and types for the operating-mode and watchdog controller.
 * Assumes a single 10 MHz system clock; all times are derived from its period.
 */
`default_nettype none
package mode_watchdog_pkg;

    // ************************************************************
    // clock and time base
    // ************************************************************
    localparam int CLK_PERIOD_NS   = 100;
    localparam int MS_NS           = 1000000;
    localparam int CYCLES_PER_MS   = MS_NS / CLK_PERIOD_NS;
    localparam int SLEEP_ENTRY_MS  = 1;      // sleep entry time in ms
    localparam int DET_PWM_MS      = 1;      // wake detection time in ms

    // ************************************************************
    // standby thresholds
    // ************************************************************
    localparam logic [1:0]  HYST_WIDE       = 2'h3;
    localparam logic [6:0]  THR_PCT_NARROW  = 7'h01;
    localparam logic [6:0]  THR_PCT_WIDE    = 7'h02;
    localparam logic [6:0]  PCT_SCALE       = 7'h64;
    localparam logic [15:0] I2C_THR_NARROW  = 16'h0148;  // 328 counts
    localparam logic [15:0] I2C_THR_WIDE    = 16'h0290;  // 656 counts

    // ************************************************************
    // modes and states
    // ************************************************************
    typedef enum logic [1:0] {SPEED_ANALOG, SPEED_PWM, SPEED_I2C, SPEED_FREQ} speed_mode_e;
    typedef enum logic [1:0] {ST_RUN, ST_STANDBY, ST_SLEEP} op_state_e;

    // ************************************************************
    // watchdog intervals in ms, indexed by the interval select
    // ************************************************************
    localparam logic [13:0] WD_PIN_MS [0:3] = '{14'h0064, 14'h00C8, 14'h01F4, 14'h03E8};
    localparam logic [13:0] WD_I2C_MS [0:3] = '{14'h03E8, 14'h07D0, 14'h1388, 14'h2710};

    // ************************************************************
    // pin routing and clock selection codes
    // ************************************************************
    localparam logic [1:0]  PIN3_DAC_B      = 2'h0;
    localparam logic [1:0]  PIN3_CSA        = 2'h1;
    localparam logic [1:0]  CLK_SEL_EXT     = 2'h3;
    localparam logic [11:0] REF_KHZ_BASE    = 12'h008;  // lowest reference rate in kHz
    localparam logic [11:0] DAC_CODE_RESET  = 12'h000;

endpackage
`default_nettype wire

/* monitor_dac_channel.sv */
/*
 * One monitor DAC channel: fetches an internal variable by address and
 * holds the top twelve bits as the DAC code.
 * Assumes the variable read port answers combinationally in the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module monitor_dac_channel #(
    parameter int ADDR_W = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] var_address,
    input  wire logic [31:0]       var_data,
    output logic      [ADDR_W-1:0] var_read_address,
    output logic      [11:0]       dac_code
);
    logic [ADDR_W-1:0] next_var_read_address;
    logic [11:0]       next_dac_code;

    // ************************************************************
    // address follows the setting, code tracks the fetched value
    // ************************************************************
    always_comb begin
        next_var_read_address = var_address;
        next_dac_code         = var_data[31:20];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            var_read_address <= '0;
            dac_code         <= mode_watchdog_pkg::DAC_CODE_RESET;
        end else begin
            var_read_address <= next_var_read_address;
            dac_code         <= next_dac_code;
        end
    end
endmodule
`default_nettype wire

/* mode_watchdog_ctrl.sv */
/*
 * Operating-mode, fault-recovery, pin-routing, clock and host watchdog
 * control for a sensorless motor driver.
 * Assumes configuration comes from same-clock logic; pins are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module mode_watchdog_ctrl #(
    parameter int MS_CYCLES  = mode_watchdog_pkg::CYCLES_PER_MS,
    parameter int SLEEP_MS   = mode_watchdog_pkg::SLEEP_ENTRY_MS,
    parameter int WAKE_MS    = mode_watchdog_pkg::DET_PWM_MS,
    parameter int ADDR_W     = 16
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic [1:0]        speed_input_mode,
    input  wire logic [15:0]       speed_measure,
    input  wire logic [15:0]       speed_full_scale,
    input  wire logic [15:0]       digital_speed_cmd,
    input  wire logic              speed_pin_in,
    input  wire logic              idle_state_select,
    input  wire logic [1:0]        standby_hysteresis_sel,
    input  wire logic              latched_fault_event,
    input  wire logic              fault_condition_active,
    input  wire logic              fault_clear,
    input  wire logic              driver_off_in,
    input  wire logic [ADDR_W-1:0] monitor_a_var_address,
    input  wire logic [ADDR_W-1:0] monitor_b_var_address,
    input  wire logic [31:0]       monitor_a_var_data,
    input  wire logic [31:0]       monitor_b_var_data,
    input  wire logic              dual_pin_dac_config,
    input  wire logic [1:0]        third_pin_config,
    input  wire logic [1:0]        clock_source_sel,
    input  wire logic              reference_clock_enable,
    input  wire logic [2:0]        reference_clock_freq_sel,
    input  wire logic              reference_clock_in,
    input  wire logic              clock_dither_disable,
    input  wire logic              host_watchdog_enable,
    input  wire logic              watchdog_tickle_pin,
    input  wire logic              watchdog_tickle_i2c,
    input  wire logic              watchdog_source_sel,
    input  wire logic [1:0]        watchdog_interval_sel,
    input  wire logic              watchdog_fault_action,
    output logic [1:0]             op_state,
    output logic                   power_switch_enable,
    output logic                   gates_hiz,
    output logic                   sense_amp_enable,
    output logic                   buck_enable,
    output logic                   charge_pump_enable,
    output logic                   aux_ldo_enable,
    output logic                   i2c_port_enable,
    output logic                   latched_shutdown,
    output logic                   watchdog_fault_status,
    output logic [ADDR_W-1:0]      monitor_a_read_address,
    output logic [ADDR_W-1:0]      monitor_b_read_address,
    output logic [11:0]            monitor_dac_a,
    output logic [11:0]            monitor_dac_b,
    output logic                   dac_pins_enable,
    output logic                   third_pin_dac_b,
    output logic                   current_sense_out,
    output logic                   osc_internal,
    output logic                   osc_calibrating,
    output logic                   osc_trim_up,
    output logic                   osc_trim_down,
    output logic                   clock_dither_enable
);
    // ************************************************************
    // helpers
    // ************************************************************
    // value below pct of full scale, compared without division
    function automatic logic below_pct(input logic [15:0] v, input logic [15:0] fs,
                                       input logic [6:0] pct);
        below_pct = (32'(v) * 32'(mode_watchdog_pkg::PCT_SCALE)) < (32'(fs) * 32'(pct));
    endfunction

    function automatic logic above_pct(input logic [15:0] v, input logic [15:0] fs,
                                       input logic [6:0] pct);
        above_pct = (32'(v) * 32'(mode_watchdog_pkg::PCT_SCALE)) > (32'(fs) * 32'(pct));
    endfunction

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic speed_s1, speed_s2, driver_off_in_s1, driver_off_in_s2;
    logic wdpin_s1, wdpin_s2, wdpin_s3, refc_s1, refc_s2, refc_s3;

    // two flops per pin; third stage only feeds edge detection
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {speed_s1, speed_s2, driver_off_in_s1, driver_off_in_s2} <= 4'h0;
            {wdpin_s1, wdpin_s2, wdpin_s3, refc_s1, refc_s2, refc_s3} <= 6'h00;
        end else begin
            speed_s1  <= speed_pin_in;
            speed_s2  <= speed_s1;
            driver_off_in_s1 <= driver_off_in;
            driver_off_in_s2 <= driver_off_in_s1;
            wdpin_s1  <= watchdog_tickle_pin;
            wdpin_s2  <= wdpin_s1;
            wdpin_s3  <= wdpin_s2;
            refc_s1   <= reference_clock_in;
            refc_s2   <= refc_s1;
            refc_s3   <= refc_s2;
        end
    end

    // ************************************************************
    // millisecond tick divider
    // ************************************************************
    logic [31:0] ms_div, next_ms_div;
    logic        ms_tick;

    always_comb begin
        ms_tick     = (ms_div == 32'(MS_CYCLES - 1));
        next_ms_div = ms_tick ? 32'h0 : ms_div + 32'h1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) ms_div <= 32'h0;
        else        ms_div <= next_ms_div;
    end

    // ************************************************************
    // operating state, faults and watchdog
    // ************************************************************
    mode_watchdog_pkg::op_state_e state, next_state;
    logic [15:0] sleep_ms, next_sleep_ms, wake_ms, next_wake_ms;
    logic [13:0] wd_ms, next_wd_ms, wd_limit;
    logic        next_latched, next_wd_status, wd_timeout, tickle, i2c_mode, wide;
    logic        below_thr, above_thr, sleep_cond;

    always_comb begin
        i2c_mode  = (speed_input_mode == 2'(mode_watchdog_pkg::SPEED_I2C));
        wide      = (standby_hysteresis_sel == mode_watchdog_pkg::HYST_WIDE);
        if (i2c_mode) begin
            below_thr = digital_speed_cmd < (wide ? mode_watchdog_pkg::I2C_THR_WIDE
                                                  : mode_watchdog_pkg::I2C_THR_NARROW);
            above_thr = digital_speed_cmd > (wide ? mode_watchdog_pkg::I2C_THR_WIDE
                                                  : mode_watchdog_pkg::I2C_THR_NARROW);
        end else begin
            below_thr = below_pct(speed_measure, speed_full_scale,
                        wide ? mode_watchdog_pkg::THR_PCT_WIDE : mode_watchdog_pkg::THR_PCT_NARROW);
            above_thr = above_pct(speed_measure, speed_full_scale,
                        wide ? mode_watchdog_pkg::THR_PCT_WIDE : mode_watchdog_pkg::THR_PCT_NARROW);
        end
        // sleep only counts in I2C mode with sleep chosen as idle state
        sleep_cond = i2c_mode && idle_state_select && (digital_speed_cmd == 16'h0000)
                     && !speed_s2;
        next_sleep_ms = !sleep_cond ? 16'h0000
                      : (ms_tick && sleep_ms != 16'hFFFF) ? sleep_ms + 16'h1 : sleep_ms;
        next_wake_ms  = (state != mode_watchdog_pkg::ST_SLEEP || !speed_s2) ? 16'h0000
                      : (ms_tick && wake_ms != 16'hFFFF) ? wake_ms + 16'h1 : wake_ms;
        next_state = state;
        unique case (state)
            mode_watchdog_pkg::ST_RUN:
                if (below_thr) next_state = mode_watchdog_pkg::ST_STANDBY;
            mode_watchdog_pkg::ST_STANDBY:
                if (sleep_ms >= 16'(SLEEP_MS)) next_state = mode_watchdog_pkg::ST_SLEEP;
                else if (above_thr) next_state = mode_watchdog_pkg::ST_RUN;
            mode_watchdog_pkg::ST_SLEEP:
                if (wake_ms >= 16'(WAKE_MS)) next_state = mode_watchdog_pkg::ST_STANDBY;
            default: next_state = mode_watchdog_pkg::ST_STANDBY;
        endcase
        // watchdog interval from source and interval select
        wd_limit = watchdog_source_sel ? mode_watchdog_pkg::WD_I2C_MS[watchdog_interval_sel]
                                       : mode_watchdog_pkg::WD_PIN_MS[watchdog_interval_sel];
        tickle   = watchdog_source_sel ? watchdog_tickle_i2c : (wdpin_s2 && !wdpin_s3);
        wd_timeout = host_watchdog_enable && ms_tick && (wd_ms >= wd_limit - 14'h1);
        if (!host_watchdog_enable) next_wd_ms = 14'h0000;
        else if (tickle || wd_timeout) next_wd_ms = 14'h0000;
        else if (ms_tick) next_wd_ms = wd_ms + 14'h1;
        else next_wd_ms = wd_ms;
        // set wins over clear for both sticky flags
        next_wd_status = wd_timeout || (watchdog_fault_status && !fault_clear);
        next_latched   = latched_fault_event || (wd_timeout && watchdog_fault_action)
                       || (latched_shutdown && !(fault_clear && !fault_condition_active));
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state                 <= mode_watchdog_pkg::ST_STANDBY;
            sleep_ms              <= 16'h0000;
            wake_ms               <= 16'h0000;
            wd_ms                 <= 14'h0000;
            watchdog_fault_status <= 1'b0;
            latched_shutdown      <= 1'b0;
        end else begin
            state                 <= next_state;
            sleep_ms              <= next_sleep_ms;
            wake_ms               <= next_wake_ms;
            wd_ms                 <= next_wd_ms;
            watchdog_fault_status <= next_wd_status;
            latched_shutdown      <= next_latched;
        end
    end

    // ************************************************************
    // power domain enables and gate control
    // ************************************************************
    logic next_sw_en, next_sa_en, next_supply_en;

    // report-only watchdog faults never reach the gates
    always_comb begin
        next_supply_en = (next_state != mode_watchdog_pkg::ST_SLEEP);
        next_sa_en     = (next_state == mode_watchdog_pkg::ST_RUN);
        next_sw_en     = next_sa_en && !next_latched && !driver_off_in_s2;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            op_state            <= 2'(mode_watchdog_pkg::ST_STANDBY);
            power_switch_enable <= 1'b0;
            gates_hiz           <= 1'b1;
            sense_amp_enable    <= 1'b0;
            {buck_enable, charge_pump_enable, aux_ldo_enable, i2c_port_enable} <= 4'hF;
        end else begin
            op_state            <= 2'(next_state);
            power_switch_enable <= next_sw_en;
            gates_hiz           <= !next_sw_en;
            sense_amp_enable    <= next_sa_en;
            {buck_enable, charge_pump_enable, aux_ldo_enable, i2c_port_enable}
                <= {4{next_supply_en}};
        end
    end

    // ************************************************************
    // monitor DACs and shared pin routing
    // ************************************************************
    monitor_dac_channel #(.ADDR_W(ADDR_W)) u_dac_a (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .var_address      (monitor_a_var_address),
        .var_data         (monitor_a_var_data),
        .var_read_address (monitor_a_read_address),
        .dac_code         (monitor_dac_a)
    );

    monitor_dac_channel #(.ADDR_W(ADDR_W)) u_dac_b (
        .ref_clk          (ref_clk),
        .rst_n            (rst_n),
        .var_address      (monitor_b_var_address),
        .var_data         (monitor_b_var_data),
        .var_read_address (monitor_b_read_address),
        .dac_code         (monitor_dac_b)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            {dac_pins_enable, third_pin_dac_b, current_sense_out} <= 3'h0;
        end else begin
            dac_pins_enable   <= dual_pin_dac_config;
            third_pin_dac_b   <= (third_pin_config == mode_watchdog_pkg::PIN3_DAC_B);
            current_sense_out <= (third_pin_config == mode_watchdog_pkg::PIN3_CSA);
        end
    end

    // ************************************************************
    // oscillator source, calibration and dither
    // ************************************************************
    logic [11:0] ref_edges, next_ref_edges, ref_expect;
    logic        cal_on, next_up, next_down;

    // reference counted over 1 ms; limited to rates well under ref_clk / 2
    always_comb begin
        cal_on     = (clock_source_sel == mode_watchdog_pkg::CLK_SEL_EXT)
                     && reference_clock_enable;
        ref_expect = mode_watchdog_pkg::REF_KHZ_BASE << reference_clock_freq_sel;
        if (!cal_on || ms_tick) next_ref_edges = 12'h000;
        else if (refc_s2 && !refc_s3 && ref_edges != 12'hFFF) next_ref_edges = ref_edges + 12'h1;
        else next_ref_edges = ref_edges;
        next_up   = cal_on && ms_tick && (ref_edges > ref_expect);
        next_down = cal_on && ms_tick && (ref_edges < ref_expect);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ref_edges           <= 12'h000;
            osc_internal        <= 1'b1;
            osc_calibrating     <= 1'b0;
            osc_trim_up         <= 1'b0;
            osc_trim_down       <= 1'b0;
            clock_dither_enable <= 1'b0;
        end else begin
            ref_edges           <= next_ref_edges;
            osc_internal        <= 1'b1;
            osc_calibrating     <= cal_on;
            osc_trim_up         <= next_up;
            osc_trim_down       <= next_down;
            clock_dither_enable <= !clock_dither_disable;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_sleep_powers_off: assert property (op_state == 2'(mode_watchdog_pkg::ST_SLEEP)
        |-> !buck_enable && !i2c_port_enable && !power_switch_enable)
        else $error("sleep left a domain powered");
    a_standby_supplies: assert property (op_state == 2'(mode_watchdog_pkg::ST_STANDBY)
        |-> charge_pump_enable && aux_ldo_enable && i2c_port_enable)
        else $error("standby supplies off");
    a_sleep_needs_sel: assert property (state != mode_watchdog_pkg::ST_SLEEP
        && next_state == mode_watchdog_pkg::ST_SLEEP |-> idle_state_select && i2c_mode)
        else $error("sleep entered without sleep selection");
    a_i2c_threshold: assert property (i2c_mode && !wide
        && digital_speed_cmd == 16'h0147 |-> below_thr)
        else $error("i2c standby threshold wrong");
    a_driver_off_in_hiz: assert property (driver_off_in_s2 |=> gates_hiz)
        else $error("switches driven while driver off");
    a_latch_holds: assert property (latched_shutdown && !fault_clear |=> latched_shutdown)
        else $error("latched shutdown dropped without clear");
    a_clear_releases: assert property (latched_shutdown && fault_clear
        && !fault_condition_active && !latched_fault_event && !wd_timeout
        |=> !latched_shutdown)
        else $error("fault clear ignored");
    a_wd_timeout_sets: assert property (wd_timeout |=> watchdog_fault_status
        && (latched_shutdown == $past(watchdog_fault_action) || $past(latched_fault_event)
            || $past(latched_shutdown)))
        else $error("watchdog timeout not reported");
    a_wd_disabled_clear: assert property (!host_watchdog_enable |=> wd_ms == 14'h0000)
        else $error("watchdog counter runs while disabled");
    a_tickle_restarts: assert property (host_watchdog_enable && tickle |=> wd_ms == 14'h0000)
        else $error("tickle did not restart interval");
    a_report_only: assert property (wd_timeout && !watchdog_fault_action && !latched_shutdown
        && !latched_fault_event |=> !latched_shutdown)
        else $error("report-only fault latched");
    a_csa_route: assert property (third_pin_config == mode_watchdog_pkg::PIN3_CSA
        |=> current_sense_out && !third_pin_dac_b)
        else $error("current sense not routed");
endmodule
`default_nettype wire

/* host_tickle_model.sv */
/* host side model: feeds the watchdog pin with periodic rising edges
   assumes the bench clock and a tickle period given in cycles */
`timescale 1ns/1ps
`default_nettype none
module host_tickle_model (
    input  wire logic        ref_clk,
    input  wire logic        active,
    input  wire logic [15:0] period,
    output var  logic        tickle_pin
);
    logic [15:0] cnt = 16'h0000;
    initial tickle_pin = 1'b0;
    // square wave, so each period carries exactly one rising edge; low when idle
    always @(posedge ref_clk) begin
        cnt <= (!active || cnt >= period) ? 16'h0000 : cnt + 16'h0001;
        tickle_pin <= active && (cnt < (period >> 1));
    end
endmodule
`default_nettype wire

/* testbench.sv */
/* self-checking bench for the mode and watchdog controller
   assumes a short ms tick (MS_CYCLES 20) so the watchdog runs in a few thousand cycles */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk = '0, rst_n = '0, speed_pin_in = '0, idle_state_select = '0, host_on = '0;
    logic latched_fault_event = '0, fault_condition_active = '0, fault_clear = '0;
    logic driver_off_in = '0, dual_pin_dac_config = '0, reference_clock_enable = '0;
    logic reference_clock_in = '0, clock_dither_disable = '0, host_watchdog_enable = '0;
    logic watchdog_tickle_pin, watchdog_tickle_i2c = '0, watchdog_source_sel = '0;
    logic watchdog_fault_action = '0, power_switch_enable, gates_hiz, sense_amp_enable;
    logic [1:0] speed_input_mode = '0, standby_hysteresis_sel = '0, third_pin_config = '0;
    logic [1:0] clock_source_sel = '0, watchdog_interval_sel = '0, op_state;
    logic [2:0] reference_clock_freq_sel = '0;
    logic [15:0] speed_measure = '0, speed_full_scale = 16'h2710, digital_speed_cmd = '0, v;
    logic [15:0] monitor_a_var_address = '0, monitor_b_var_address = '0;
    logic [15:0] monitor_a_read_address, monitor_b_read_address;
    logic [31:0] monitor_a_var_data = '0, monitor_b_var_data = '0;
    logic [11:0] monitor_dac_a, monitor_dac_b;
    logic buck_enable, charge_pump_enable, aux_ldo_enable, i2c_port_enable, latched_shutdown;
    logic watchdog_fault_status, dac_pins_enable, third_pin_dac_b, current_sense_out;
    logic osc_internal, osc_calibrating, osc_trim_up, osc_trim_down, clock_dither_enable;
    int mismatches = 0, compares = 0, cycles = 0;
    mode_watchdog_ctrl #(.MS_CYCLES(20)) DUT (.*);
    host_tickle_model host (.ref_clk, .active(host_on), .period(16'h0258),
        .tickle_pin(watchdog_tickle_pin));
    always #50 ref_clk = ~ref_clk;
    // hang guard, plus random reference clock activity
    always @(posedge ref_clk) begin
        cycles++;
        reference_clock_in <= 1'($urandom_range(0, 1));
        if (cycles == 20000) begin
            mismatches++;
            end_of_test();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // settle on the falling edge so the sampled values are never racing
    task automatic look(input int n);
        cyc(n);
        @(negedge ref_clk);
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // standby threshold: i2c counts, else percent of full scale 10000
    function automatic logic [15:0] thr(input logic [1:0] m, input logic [1:0] h);
        if (m == 2'h2) return (h == 2'h3) ? 16'h0290 : 16'h0148;
        return (h == 2'h3) ? 16'h00C8 : 16'h0064;
    endfunction
    initial begin
        void'($urandom(32'hCDC0F1ED));
        cyc(20);
        rst_n <= 1'b1;
        look(1);
        chk("reset", 16'h007F, {op_state, charge_pump_enable, aux_ldo_enable, buck_enable,
            i2c_port_enable, osc_internal, gates_hiz});
        for (int i = 0; i < 4; i++) begin
            cyc(1);
            v = thr(2'(i), 2'(3 - i)) + 16'h1;
            speed_input_mode <= 2'(i);
            standby_hysteresis_sel <= 2'(3 - i);
            speed_measure <= v;
            digital_speed_cmd <= v;
            look(1);
            chk("exit standby", 16'h1, {op_state, power_switch_enable});
            cyc(1);
            speed_measure <= v - 16'h2;
            digital_speed_cmd <= v - 16'h2;
            look(1);
            chk("enter standby", 16'h2, {op_state, power_switch_enable});
        end
        cyc(1);
        speed_input_mode <= 2'h2;
        digital_speed_cmd <= '0;
        look(60);
        chk("standby idle", 16'h1, op_state);
        cyc(1);
        idle_state_select <= 1'b1;
        look(60);
        chk("sleep", 16'h0080, {op_state, buck_enable, charge_pump_enable, aux_ldo_enable,
            i2c_port_enable, sense_amp_enable, power_switch_enable});
        cyc(1);
        speed_pin_in <= 1'b1;
        look(60);
        chk("wake", 16'h3, {op_state, i2c_port_enable});
        cyc(1);
        digital_speed_cmd <= 16'h1000;
        idle_state_select <= 1'b0;
        driver_off_in <= 1'b1;
        look(4);
        chk("driver off", 16'h1, {op_state, gates_hiz});
        cyc(1);
        driver_off_in <= 1'b0;
        latched_fault_event <= 1'b1;
        fault_condition_active <= 1'b1;
        cyc(1);
        latched_fault_event <= 1'b0;
        fault_clear <= 1'b1;
        cyc(1);
        fault_clear <= 1'b0;
        look(4);
        chk("latched", 16'h3, {latched_shutdown, gates_hiz});
        cyc(1);
        fault_condition_active <= 1'b0;
        fault_clear <= 1'b1;
        cyc(1);
        fault_clear <= 1'b0;
        look(4);
        chk("recovered", 16'h0, {latched_shutdown, gates_hiz});
        cyc(1);
        monitor_a_var_data <= $urandom;
        monitor_b_var_data <= $urandom;
        monitor_a_var_address <= 16'($urandom);
        monitor_b_var_address <= 16'($urandom);
        reference_clock_freq_sel <= 3'($urandom);
        {dual_pin_dac_config, reference_clock_enable, clock_dither_disable} <= 3'h7;
        clock_source_sel <= 2'h3;
        look(3);
        chk("dac a", {4'h0, monitor_a_var_data[31:20]}, monitor_dac_a);
        chk("dac b", {4'h0, monitor_b_var_data[31:20]}, monitor_dac_b);
        chk("address a", monitor_a_var_address, monitor_a_read_address);
        chk("address b", monitor_b_var_address, monitor_b_read_address);
        chk("routing", 16'h001A, {dac_pins_enable, third_pin_dac_b, current_sense_out,
            osc_calibrating, clock_dither_enable});
        cyc(1);
        third_pin_config <= 2'h1;
        host_on <= 1'b1;
        host_watchdog_enable <= 1'b1;
        look(3000);
        chk("sense route", 16'h1, {third_pin_dac_b, current_sense_out});
        chk("fed watchdog", 16'h0, watchdog_fault_status);
        cyc(1);
        host_on <= 1'b0;
        look(2200);
        chk("report only", 16'h4, {watchdog_fault_status, latched_shutdown, gates_hiz});
        cyc(1);
        host_watchdog_enable <= 1'b0;
        fault_clear <= 1'b1;
        cyc(1);
        fault_clear <= 1'b0;
        watchdog_fault_action <= 1'b1;
        host_watchdog_enable <= 1'b1;
        look(2200);
        chk("latched watchdog", 16'h7, {watchdog_fault_status, latched_shutdown,
            gates_hiz});
        end_of_test();
    end
endmodule
`default_nettype wire
